// file: design/aurw_pkg.sv
// Package: register map, field positions, reset values and states of the receiver
package aurw_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RX_DATA = 8'h04;
  localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_BAUD_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_BAUD_DIVISOR_HIGH = 8'h10;
  localparam logic [7:0] OFS_BAUD_DIVISOR_LOW = 8'h14;
  localparam logic [7:0] OFS_IRQ_CONTROL = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Receive status and control
  localparam int BIT_SERIAL_PORT_ENABLE = 7;
  localparam int BIT_NINTH_BIT_RECEIVE_ENABLE = 6;
  localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int BIT_ADDRESS_DETECT_ENABLE = 3;
  localparam int BIT_FRAMING_ERROR = 2;
  localparam int BIT_OVERRUN_ERROR = 1;
  localparam int BIT_RECEIVED_NINTH_BIT = 0;
  // Transmit status and control
  localparam int BIT_SYNC_MODE = 4;
  localparam int BIT_HIGH_SPEED_BAUD_SELECT = 2;
  // Baud control
  localparam int BIT_RECEIVE_IDLE = 6;
  localparam int BIT_WIDE_BAUD_GENERATOR_SELECT = 3;
  localparam int BIT_WAKE_ON_EDGE_ENABLE = 1;
  // Interrupt control
  localparam int BIT_RECEIVE_IRQ_ENABLE = 0;
  localparam int BIT_RECEIVE_IRQ_PRIORITY = 1;
  localparam int BIT_RECEIVE_COMPLETE_FLAG = 2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_BAUD_COUNT = 16'h0000;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_START_MID = 4'h7;
  localparam logic [1:0] PRESCALE_X64_LAST = 2'h3;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;

  // Gray coded along idle, start, data, stop
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } aurw_rx_e;

endpackage

// file: design/aurw_receiver.sv
// Asynchronous serial receiver with address filter and auto wake-up, APB slave
`timescale 1ns/1ns

module aurw_receiver
  import aurw_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialReceivePin,
  input wire logic sleepMode,
  output logic rxIrq,
  output logic rxIrqHighPri,
  output logic rxIrqLowPri
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic serialPortEnable;
  logic ninthBitReceiveEnable;
  logic continuousReceiveEnable;
  logic addressDetectEnable;
  logic framingError;
  logic overrunError;
  logic receivedNinthBit;
  logic [7:0] rxData;
  logic syncMode;
  logic highSpeedBaudSelect;
  logic wideBaudGeneratorSelect;
  logic wakeOnEdgeEnable;
  logic [7:0] baudDivisorHigh;
  logic [7:0] baudDivisorLow;
  logic receiveIrqEnable;
  logic receiveIrqPriority;
  logic bufFull;
  logic wakeFlag;
  logic wakeSeen;
  logic readArmed;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic [7:0] regAddr = paddr[7:0];
  wire logic setupPhase = psel & ~penable;
  wire logic accessPhase = psel & penable;
  wire logic selRxStat = (regAddr == OFS_RX_STATUS_CONTROL);
  wire logic selRxData = (regAddr == OFS_RX_DATA);
  wire logic selTxStat = (regAddr == OFS_TX_STATUS_CONTROL);
  wire logic selBaudCtl = (regAddr == OFS_BAUD_CONTROL);
  wire logic selDivHigh = (regAddr == OFS_BAUD_DIVISOR_HIGH);
  wire logic selDivLow = (regAddr == OFS_BAUD_DIVISOR_LOW);
  wire logic selIrqCtl = (regAddr == OFS_IRQ_CONTROL);
  wire logic mapped = selRxStat | selRxData | selTxStat | selBaudCtl | selDivHigh |
                      selDivLow | selIrqCtl;
  // Only byte lane 0 carries register data
  wire logic wrEn = accessPhase & pwrite & mapped & pstrb[0];
  wire logic [7:0] wrByte = pwdata[7:0];
  wire logic dataReadDone = accessPhase & ~pwrite & selRxData;

  // Zero wait state; read data captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~mapped;

  // ----------------------------------------------------------------
  // Receive pin synchroniser and edges
  // ----------------------------------------------------------------
  logic rxMeta;
  logic rxSync;
  logic rxPrev;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxMeta <= serialReceivePin;
      rxSync <= rxMeta;
      rxPrev <= rxSync;
    end
  end

  wire logic rxFall = rxPrev & ~rxSync;
  wire logic rxRise = ~rxPrev & rxSync;

  // ----------------------------------------------------------------
  // Baud rate generator
  // ----------------------------------------------------------------
  logic [15:0] baudCount;
  logic [1:0] prescale;
  wire logic [15:0] baudDivisor = wideBaudGeneratorSelect ?
                                  {baudDivisorHigh, baudDivisorLow} :
                                  {8'h00, baudDivisorLow};
  // Clocks stop in sleep; the generator is held at count zero
  wire logic baudRun = serialPortEnable & ~syncMode & ~sleepMode;
  wire logic baudTick = baudRun & (baudCount == RST_BAUD_COUNT);
  // Both select bits low: generator runs at x64, so divide by four to x16
  wire logic slowMode = ~highSpeedBaudSelect & ~wideBaudGeneratorSelect;
  wire logic ovsTick = baudTick & (~slowMode | (prescale == PRESCALE_X64_LAST));

  always_ff @(posedge clk_sys) begin
    if (rst || !baudRun) begin
      baudCount <= RST_BAUD_COUNT;
      prescale <= 2'h0;
    end else if (baudTick) begin
      baudCount <= baudDivisor;
      prescale <= slowMode ? prescale + 2'h1 : 2'h0;
    end else begin
      baudCount <= baudCount - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Receive sequencer
  // ----------------------------------------------------------------
  aurw_rx_e rxState;
  aurw_rx_e next_rxState;
  logic [3:0] ovsCount;
  logic [3:0] bitCount;
  logic [8:0] shiftReg;

  // Wake monitor only counts in asynchronous mode
  wire logic wakeActive = wakeOnEdgeEnable & serialPortEnable & ~syncMode;
  wire logic rxEnable = serialPortEnable & continuousReceiveEnable & ~syncMode &
                        ~wakeActive & ~overrunError & ~sleepMode;
  wire logic [3:0] lastBit = ninthBitReceiveEnable ? DATA_BITS_9 : DATA_BITS_8;
  wire logic midBit = ovsTick & (ovsCount == OVS_LAST);
  wire logic startOk = ovsTick & (ovsCount == OVS_START_MID) & ~rxSync;
  wire logic startBad = ovsTick & (ovsCount == OVS_START_MID) & rxSync;
  wire logic charDone = (rxState == RX_STOP) & midBit;
  wire logic stopLow = ~rxSync;
  // Eight bit mode: the byte sits in the top eight of the shifter
  wire logic [7:0] charByte = ninthBitReceiveEnable ? shiftReg[7:0] : shiftReg[8:1];
  wire logic charNinth = ninthBitReceiveEnable & shiftReg[8];
  wire logic addrFilter = addressDetectEnable & ninthBitReceiveEnable;
  wire logic charAccept = ~addrFilter | charNinth;
  wire logic loadChar = charDone & charAccept & ~bufFull;
  wire logic overrunHit = charDone & charAccept & bufFull;

  always_comb begin
    next_rxState = rxState;
    case (rxState)
      RX_IDLE: begin
        if (rxFall) begin
          next_rxState = RX_START;
        end
      end
      RX_START: begin
        if (startOk) begin
          next_rxState = RX_DATA;
        end else if (startBad) begin
          next_rxState = RX_IDLE;
        end
      end
      RX_DATA: begin
        if (midBit && (bitCount == lastBit - 4'h1)) begin
          next_rxState = RX_STOP;
        end
      end
      RX_STOP: begin
        if (midBit) begin
          next_rxState = RX_IDLE;
        end
      end
      default: begin
        next_rxState = RX_IDLE;
      end
    endcase
    if (!rxEnable) begin
      next_rxState = RX_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxState <= RX_IDLE;
    end else begin
      rxState <= next_rxState;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || rxState == RX_IDLE || (rxState == RX_START && startOk)) begin
      ovsCount <= 4'h0;
    end else if (ovsTick) begin
      ovsCount <= ovsCount + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || rxState != RX_DATA) begin
      bitCount <= 4'h0;
    end else if (midBit) begin
      bitCount <= bitCount + 4'h1;
    end
  end

  // LSB first: new bits enter at the top and move down
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shiftReg <= 9'h000;
    end else if (rxState == RX_DATA && midBit) begin
      shiftReg <= {rxSync, shiftReg[8:1]};
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer, flags and errors
  // ----------------------------------------------------------------
  wire logic crenClear = wrEn & selRxStat & ~wrByte[BIT_CONTINUOUS_RECEIVE_ENABLE];

  // A completion on the clearing edge wins over the read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bufFull <= 1'b0;
      rxData <= RST_BYTE;
      receivedNinthBit <= 1'b0;
      framingError <= 1'b0;
    end else if (loadChar) begin
      bufFull <= 1'b1;
      rxData <= charByte;
      receivedNinthBit <= charNinth;
      framingError <= stopLow;
    end else if (crenClear) begin
      framingError <= 1'b0;
      if (dataReadDone && readArmed) begin
        bufFull <= 1'b0;
      end
    end else if (dataReadDone && readArmed) begin
      bufFull <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overrunError <= 1'b0;
    end else if (overrunHit) begin
      overrunError <= 1'b1;
    end else if (crenClear) begin
      overrunError <= 1'b0;
    end
  end

  // Read clears only what was captured; a load between capture and access is kept
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readArmed <= 1'b0;
    end else if (setupPhase) begin
      readArmed <= selRxData & ~pwrite & ~loadChar;
    end else if (loadChar) begin
      readArmed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Auto wake-up monitor
  // ----------------------------------------------------------------
  wire logic wakeEvent = wakeActive & ~wakeSeen & rxFall;
  wire logic wakeDone = wakeActive & wakeSeen & rxRise;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wakeSeen <= 1'b0;
    end else if (wakeEvent) begin
      wakeSeen <= 1'b1;
    end else if (wakeDone || !wakeActive) begin
      wakeSeen <= 1'b0;
    end
  end

  // Runs in sleep too; the flag is what lets the core wake
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wakeFlag <= 1'b0;
    end else if (wakeEvent) begin
      wakeFlag <= 1'b1;
    end else if (dataReadDone) begin
      wakeFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serialPortEnable <= 1'b0;
      ninthBitReceiveEnable <= 1'b0;
      continuousReceiveEnable <= 1'b0;
      addressDetectEnable <= 1'b0;
    end else if (wrEn && selRxStat) begin
      serialPortEnable <= wrByte[BIT_SERIAL_PORT_ENABLE];
      ninthBitReceiveEnable <= wrByte[BIT_NINTH_BIT_RECEIVE_ENABLE];
      continuousReceiveEnable <= wrByte[BIT_CONTINUOUS_RECEIVE_ENABLE];
      addressDetectEnable <= wrByte[BIT_ADDRESS_DETECT_ENABLE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncMode <= 1'b0;
      highSpeedBaudSelect <= 1'b0;
      wideBaudGeneratorSelect <= 1'b0;
      baudDivisorHigh <= RST_BYTE;
      baudDivisorLow <= RST_BYTE;
      receiveIrqEnable <= 1'b0;
      receiveIrqPriority <= 1'b0;
    end else if (wrEn) begin
      if (selTxStat) begin
        syncMode <= wrByte[BIT_SYNC_MODE];
        highSpeedBaudSelect <= wrByte[BIT_HIGH_SPEED_BAUD_SELECT];
      end
      if (selBaudCtl) begin
        wideBaudGeneratorSelect <= wrByte[BIT_WIDE_BAUD_GENERATOR_SELECT];
      end
      if (selDivHigh) begin
        baudDivisorHigh <= wrByte;
      end
      if (selDivLow) begin
        baudDivisorLow <= wrByte;
      end
      if (selIrqCtl) begin
        receiveIrqEnable <= wrByte[BIT_RECEIVE_IRQ_ENABLE];
        receiveIrqPriority <= wrByte[BIT_RECEIVE_IRQ_PRIORITY];
      end
    end
  end

  // Software write wins over the hardware auto-clear on the same edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wakeOnEdgeEnable <= 1'b0;
    end else if (wrEn && selBaudCtl) begin
      wakeOnEdgeEnable <= wrByte[BIT_WAKE_ON_EDGE_ENABLE];
    end else if (wakeDone) begin
      wakeOnEdgeEnable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs and read data
  // ----------------------------------------------------------------
  wire logic receiveCompleteFlag = bufFull | wakeFlag;
  assign rxIrq = receiveCompleteFlag & receiveIrqEnable;
  assign rxIrqHighPri = rxIrq & receiveIrqPriority;
  assign rxIrqLowPri = rxIrq & ~receiveIrqPriority;

  wire logic [7:0] rxStatByte = {serialPortEnable, ninthBitReceiveEnable, 1'b0,
                                 continuousReceiveEnable, addressDetectEnable,
                                 framingError, overrunError, receivedNinthBit};
  wire logic [7:0] txStatByte = {3'h0, syncMode, 1'b0, highSpeedBaudSelect, 2'h0};
  wire logic [7:0] baudCtlByte = {1'b0, rxState == RX_IDLE, 1'b0, 1'b0,
                                  wideBaudGeneratorSelect, 1'b0, wakeOnEdgeEnable, 1'b0};
  wire logic [7:0] irqCtlByte = {5'h00, receiveCompleteFlag, receiveIrqPriority,
                                 receiveIrqEnable};
  wire logic [7:0] readByte = selRxStat ? rxStatByte :
                              selRxData ? rxData :
                              selTxStat ? txStatByte :
                              selBaudCtl ? baudCtlByte :
                              selDivHigh ? baudDivisorHigh :
                              selDivLow ? baudDivisorLow :
                              selIrqCtl ? irqCtlByte : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (setupPhase && !pwrite) begin
      prdata <= {24'h000000, readByte};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wake_start;
    wakeActive && !wakeSeen && rxFall;
  endsequence

  sequence s_wake_end;
    wakeActive && wakeSeen && rxRise && !(wrEn && selBaudCtl);
  endsequence

  a_flag_on_load: assert property (@(posedge clk_sys) disable iff (rst)
    loadChar |=> bufFull && rxData == $past(charByte))
    else $error("Loaded character did not set the flag");

  a_irq_enable_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (bufFull && !receiveIrqEnable) |-> !rxIrq && !rxIrqHighPri && !rxIrqLowPri)
    else $error("Interrupt raised while disabled");

  a_continuous_receive_enable_clears_err: assert property (@(posedge clk_sys) disable iff (rst)
    (crenClear && !loadChar && !overrunHit) |=> !overrunError && !framingError)
    else $error("Errors survived clearing receive enable");

  a_wue_holds_idle: assert property (@(posedge clk_sys) disable iff (rst)
    wakeActive |=> rxState == RX_IDLE)
    else $error("Receiver ran while wake monitor active");

  a_wake_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
    s_wake_start |=> wakeFlag && receiveCompleteFlag)
    else $error("Wake event did not set receive flag");

  a_wue_autoclear: assert property (@(posedge clk_sys) disable iff (rst)
    s_wake_end |=> !wakeOnEdgeEnable ##1 !wakeSeen)
    else $error("Wake enable not cleared after rising edge");

  a_read_clears_wake: assert property (@(posedge clk_sys) disable iff (rst)
    (wakeFlag && dataReadDone && !wakeEvent) |=> !wakeFlag)
    else $error("Data read did not clear wake condition");

  a_addr_filter: assert property (@(posedge clk_sys) disable iff (rst)
    (charDone && addrFilter && !charNinth && !bufFull) |=> !bufFull)
    else $error("Data character passed address filter");

  a_overrun_set: assert property (@(posedge clk_sys) disable iff (rst)
    overrunHit |=> overrunError ##1 (rxState == RX_IDLE))
    else $error("Overrun not flagged or reception not blocked");

  a_sleep_stall: assert property (@(posedge clk_sys) disable iff (rst)
    sleepMode |-> !ovsTick ##1 (rxState == RX_IDLE))
    else $error("Oversample tick ran in sleep");

  a_start_qualify: assert property (@(posedge clk_sys) disable iff (rst)
    (rxState == RX_START && startBad && rxEnable) |=> rxState == RX_IDLE)
    else $error("False start bit accepted");

endmodule

// file: tb/aurw_line_driver.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ns

module aurw_line_driver #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_sys,
  output logic serialReceivePin
);
  // Bit length in clocks; the bench changes it when the baud setup changes
  int bitClks = BIT_CLKS;

  initial begin
    serialReceivePin = 1'b1;
  end

  // ----------------------------------------------------------------
  // Line drivers
  // ----------------------------------------------------------------
  // Level changes only right after a clock edge
  task automatic holdLevel(input logic level, input int clks);
    int n;
    @(posedge clk_sys);
    serialReceivePin <= level;
    for (n = 1; n < clks; n++) begin
      @(posedge clk_sys);
    end
  endtask

  // Stop level is a knob so a broken stop bit can be sent on purpose
  task automatic sendFrame(input logic [8:0] word, input logic nine,
      input logic stopLevel, input int gapBits);
    int i;
    holdLevel(1'b0, bitClks);
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      holdLevel(word[i], bitClks);
    end
    holdLevel(stopLevel, bitClks);
    holdLevel(1'b1, gapBits * bitClks);
  endtask
endmodule

// file: tb/tb.sv
// Testbench: APB register tests and serial frames into the receiver
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end

module tb;
  import aurw_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic sleepMode = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxIrq;
  logic rxIrqHighPri;
  logic rxIrqLowPri;
  logic rxPin;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int compares = 0;
  int cfg;

  always #20 clk_sys = ~clk_sys;

  aurw_receiver aurw_receiver_i (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serialReceivePin(rxPin), .sleepMode(sleepMode), .rxIrq(rxIrq),
    .rxIrqHighPri(rxIrqHighPri), .rxIrqLowPri(rxIrqLowPri)
  );

  aurw_line_driver aurw_line_driver_i (.clk_sys(clk_sys), .serialReceivePin(rxPin));

  // ----------------------------------------------------------------
  // APB master and checks
  // ----------------------------------------------------------------
  task apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apbXfer(1'b1, a, {24'h0, d});
  endtask

  task rdChk(input logic [7:0] a, input logic [7:0] e);
    apbXfer(1'b0, a, 32'h0);
    `CHK(rd, {24'h0, e})
  endtask

  task send(input logic [8:0] w, input logic nine, input logic stp, input int gap);
    aurw_line_driver_i.sendFrame(w, nine, stp, gap);
  endtask

  task test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Whole run is under four thousand cycles; this is over seven times that
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    test_done;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rdChk(OFS_RX_STATUS_CONTROL, 8'h00);
    rdChk(OFS_TX_STATUS_CONTROL, 8'h00);
    rdChk(OFS_IRQ_CONTROL, 8'h00);
    rdChk(OFS_BAUD_DIVISOR_LOW, 8'h00);
    apbXfer(1'b0, 8'h1C, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    // One clock per tick keeps a bit at sixteen clocks
    wr(OFS_TX_STATUS_CONTROL, 8'h04);
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    wr(OFS_RX_STATUS_CONTROL, 8'h90);
    for (cfg = 0; cfg < 4; cfg++) begin
      wr(OFS_IRQ_CONTROL, cfg[7:0]);
      send({1'b0, 8'h5A ^ cfg[7:0]}, 1'b0, 1'b1, 1);
      `CHK(rxIrq, cfg[0])
      `CHK(rxIrqHighPri, cfg[0] & cfg[1])
      `CHK(rxIrqLowPri, cfg[0] & ~cfg[1])
      rdChk(OFS_IRQ_CONTROL, cfg[7:0] | 8'h04);
      rdChk(OFS_RX_DATA, 8'h5A ^ cfg[7:0]);
      rdChk(OFS_IRQ_CONTROL, cfg[7:0]);
    end
    wr(OFS_IRQ_CONTROL, 8'h01);
    wr(OFS_RX_STATUS_CONTROL, 8'hD0);
    send({1'b1, 8'h3C}, 1'b1, 1'b1, 1);
    rdChk(OFS_RX_STATUS_CONTROL, 8'hD1);
    rdChk(OFS_RX_DATA, 8'h3C);
    wr(OFS_RX_STATUS_CONTROL, 8'hD8);
    send({1'b0, 8'h11}, 1'b1, 1'b1, 1);
    rdChk(OFS_IRQ_CONTROL, 8'h01);
    send({1'b1, 8'h42}, 1'b1, 1'b1, 1);
    rdChk(OFS_IRQ_CONTROL, 8'h05);
    rdChk(OFS_RX_DATA, 8'h42);
    wr(OFS_RX_STATUS_CONTROL, 8'h90);
    send({1'b0, 8'h77}, 1'b0, 1'b0, 1);
    rdChk(OFS_RX_STATUS_CONTROL, 8'h94);
    rdChk(OFS_RX_DATA, 8'h77);
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    rdChk(OFS_RX_STATUS_CONTROL, 8'h80);
    wr(OFS_RX_STATUS_CONTROL, 8'h90);
    send({1'b0, 8'h81}, 1'b0, 1'b1, 0);
    send({1'b0, 8'h82}, 1'b0, 1'b1, 1);
    rdChk(OFS_RX_STATUS_CONTROL, 8'h92);
    rdChk(OFS_RX_DATA, 8'h81);
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    rdChk(OFS_RX_STATUS_CONTROL, 8'h80);
    wr(OFS_RX_STATUS_CONTROL, 8'h90);
    // Short low pulse must be thrown away at the start check
    aurw_line_driver_i.holdLevel(1'b0, 4);
    aurw_line_driver_i.holdLevel(1'b1, 32);
    rdChk(OFS_IRQ_CONTROL, 8'h01);
    rdChk(OFS_RX_STATUS_CONTROL, 8'h90);
    // Wake monitor must stay deaf in synchronous mode
    wr(OFS_TX_STATUS_CONTROL, 8'h14);
    wr(OFS_BAUD_CONTROL, 8'h02);
    aurw_line_driver_i.holdLevel(1'b0, 32);
    rdChk(OFS_IRQ_CONTROL, 8'h01);
    aurw_line_driver_i.holdLevel(1'b1, 8);
    wr(OFS_BAUD_CONTROL, 8'h00);
    wr(OFS_TX_STATUS_CONTROL, 8'h04);
    sleepMode <= 1'b1;
    send({1'b0, 8'h99}, 1'b0, 1'b1, 1);
    rdChk(OFS_IRQ_CONTROL, 8'h01);
    wr(OFS_BAUD_CONTROL, 8'h02);
    apbXfer(1'b0, OFS_BAUD_CONTROL, 32'h0);
    `CHK(rd & 32'hBF, 32'h02)
    aurw_line_driver_i.holdLevel(1'b0, 64);
    rdChk(OFS_IRQ_CONTROL, 8'h05);
    apbXfer(1'b0, OFS_BAUD_CONTROL, 32'h0);
    `CHK(rd & 32'hBF, 32'h02)
    aurw_line_driver_i.holdLevel(1'b1, 8);
    apbXfer(1'b0, OFS_BAUD_CONTROL, 32'h0);
    `CHK(rd & 32'hBF, 32'h00)
    apbXfer(1'b0, OFS_RX_DATA, 32'h0);
    rdChk(OFS_IRQ_CONTROL, 8'h01);
    sleepMode <= 1'b0;
    send({1'b0, 8'hC3}, 1'b0, 1'b1, 1);
    rdChk(OFS_RX_DATA, 8'hC3);
    // Both select bits low: divide by four ahead of x16, so a bit is 64 clocks
    aurw_line_driver_i.bitClks = 64;
    wr(OFS_TX_STATUS_CONTROL, 8'h00);
    send({1'b0, 8'hA5}, 1'b0, 1'b1, 1);
    rdChk(OFS_RX_DATA, 8'hA5);
    // Wide select with divisor 3: four clocks per tick, same bit length
    wr(OFS_BAUD_DIVISOR_LOW, 8'h03);
    wr(OFS_BAUD_CONTROL, 8'h08);
    send({1'b0, 8'h3A}, 1'b0, 1'b1, 1);
    rdChk(OFS_RX_DATA, 8'h3A);
    test_done;
  end
endmodule
